// ==== common/vic_pkg.sv ====
// Package of the vectored interrupt controller: register map, fields, vectors, types.
// Assumes an APB slave with 32-bit data; registers hold 8 bits in the low lanes.
package vic_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CORE_STATUS = 8'h06;
	localparam logic [7:0] IDX_STATUS_CTRL = 8'h07;
	localparam logic [7:0] IDX_PREQ2 = 8'h10;
	localparam logic [7:0] IDX_PEN2 = 8'h11;
	localparam logic [7:0] IDX_PREQ1 = 8'h16;
	localparam logic [7:0] IDX_PEN1 = 8'h17;

	// Status/control field positions
	localparam int SC_PEND = 7;
	localparam int SC_TCLK_F = 6;
	localparam int SC_T0_F = 5;
	localparam int SC_EXT_F = 4;
	localparam int SC_PGRP_E = 3;
	localparam int SC_TCLK_E = 2;
	localparam int SC_T0_E = 1;
	localparam int SC_EXT_E = 0;

	// Core status field: global disable
	localparam int CS_GID = 0;

	// Hardware-owned request bits (buffer state levels)
	localparam logic [7:0] PREQ_HW_MASK = 8'h03;
	localparam logic [7:0] PREQ2_IMPL = 8'hEF;

	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic RST_GID = 1'b1;

	// Vector addresses
	localparam logic [15:0] VEC_RESET = 16'h0000;
	localparam logic [15:0] VEC_EXT = 16'h0008;
	localparam logic [15:0] VEC_T0 = 16'h0010;
	localparam logic [15:0] VEC_TCLK = 16'h0018;
	localparam logic [15:0] VEC_PERIPH = 16'h0020;

	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_EXT = 3'b001,
		SEL_T0 = 3'b010,
		SEL_TCLK = 3'b011,
		SEL_PERIPH = 3'b100
	} vic_sel_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_ISR = 2'b01
	} vic_state_t;

	// Edge or pulse events, one per source
	typedef struct packed {
		logic ext_pin;
		logic t0_ovf;
		logic tclk_pin;
		logic port_chg;
		logic tmr3;
		logic tmr2;
		logic tmr1;
		logic cap2;
		logic cap1;
		logic ssp;
		logic bus_coll;
		logic adc_done;
		logic cap4;
		logic cap3;
	} vic_evt_t;

	// Buffer state levels of both serial ports
	typedef struct packed {
		logic tx1_empty;
		logic rx1_full;
		logic tx2_empty;
		logic rx2_full;
	} vic_lvl_t;

	// Towards the core sequencer
	typedef struct packed {
		logic push_ret;
		logic load_pc;
		logic pop_ret;
		logic [15:0] vec_addr;
	} vic_core_t;

endpackage

// ==== hw/vic_vector_arb.sv ====
// Fixed-priority vector selection for the interrupt controller.
// Purely combinational; the caller registers its results.
`timescale 1ns/10ps
module vic_vector_arb import vic_pkg::*; (
	// Status/control with pending, and global disable
	input wire logic [7:0] sc,
	input wire logic gid,
	// Selection
	output logic req,
	output vic_sel_t sel,
	output logic [15:0] vec
);

	always_comb begin
		req = 1'b0;
		sel = SEL_NONE;
		vec = VEC_RESET;
		if (!gid) begin // R2 R20
			if (sc[SC_EXT_F] && sc[SC_EXT_E]) begin // R21
				sel = SEL_EXT;
				vec = VEC_EXT;
			end else if (sc[SC_T0_F] && sc[SC_T0_E]) begin
				sel = SEL_T0;
				vec = VEC_T0;
			end else if (sc[SC_TCLK_F] && sc[SC_TCLK_E]) begin
				sel = SEL_TCLK;
				vec = VEC_TCLK;
			end else if (sc[SC_PEND] && sc[SC_PGRP_E]) begin // R20
				sel = SEL_PERIPH;
				vec = VEC_PERIPH; // R4
			end
			req = (sel != SEL_NONE);
		end
	end

endmodule // vic_vector_arb

// ==== hw/vic_top.sv ====
// Vectored interrupt controller with an APB register slave and a core sequencer port.
// Assumes the core pulses instr_end at each instruction boundary, on enabled cycles.
//
// Overview of operation
// R1: Eighteen sources: pin, port change, timers, serial, bus, converter, captures, clock edge.
// R2: Global disable set blocks every vector regardless of flags and enables.
// R3: Taking a vector sets global disable, pushes return address, loads vector.
// R4: Four vectors: external pin, timer0 overflow, clock pin edge, shared peripheral.
// R5: External pin flag is status bit 4, cleared on taking vector 08h.
// R6: Timer0 overflow flag is bit 5, cleared on taking vector 10h.
// R7: Clock pin edge flag is bit 6, cleared on taking vector 18h.
// R8: Peripheral vector leaves all peripheral request flags untouched.
// R9: Software clears serviced peripheral flags before re-enabling interrupts.
// R10: Flags set on their condition whatever enables or global disable hold.
// R11: External events are seen with latency; two-cycle instructions add one.
// R12: Return instruction pops the stack and clears global disable.
// R13: Status bit 7 reads the OR of enabled peripheral request flags.
// R14: Flag set while its enable is cleared, interrupts on, vectors to 0x00.
// R15: Software sets global disable before clearing any status enable bit.
// R16: Status bits 3..0 enable peripherals, clock edge, timer0, external; reset zero.
// R17: First peripheral enable register layout, read/write, resets to zero.
// R18: Request registers mirror the bit positions of the enable registers.
// R19: Serial transmit and receive flags follow buffer state, hardware only.
// R20: Vector requested when disable clear and flag with enable set.
// R21: Priority: external pin, timer0, clock pin edge, then peripherals.
`timescale 1ns/10ps
module vic_top import vic_pkg::*; (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt sources
	input wire vic_evt_t evt,
	input wire vic_lvl_t lvl,
	// Core sequencer
	input wire logic instr_end,
	input wire logic return_from_isr,
	output vic_core_t core,
	output logic global_irq_disable,
	output logic in_isr
);

	logic [7:0] sc_r;
	logic [7:0] pen1_r;
	logic [7:0] pen2_r;
	logic [7:0] preq1_r;
	logic [7:0] preq2_r;
	logic gid_r;
	vic_evt_t evt_r;
	vic_state_t state_r;
	logic push_r;
	logic load_r;
	logic pop_r;
	logic [15:0] vec_r;
	logic [31:0] prdata_r;
	logic slverr_r;

	logic wr_en;
	logic setup;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic [7:0] preq1_v;
	logic [7:0] preq2_v;
	logic [7:0] sc_v;
	logic pend;
	logic req;
	vic_sel_t sel;
	logic [15:0] vec;
	logic take;
	logic hazard;

	// Set wins over clear; clr marks bits written low by software or cleared by a take
	function automatic logic [7:0] set_wins(input logic [7:0] cur, input logic [7:0] set,
		input logic [7:0] clr);
		set_wins = (cur & ~clr) | set;
	endfunction

	function automatic logic mapped(input logic [7:0] i);
		mapped = (i == IDX_CORE_STATUS) || (i == IDX_STATUS_CTRL) || (i == IDX_PREQ1) ||
			(i == IDX_PEN1) || (i == IDX_PREQ2) || (i == IDX_PEN2);
	endfunction

	assign idx = paddr[9:2];
	assign wbyte = pwdata[7:0];
	assign setup = psel && !penable;
	assign wr_en = ce && psel && penable && pwrite && mapped(idx) && (paddr[11:10] == 2'b00);
	assign pready = ce;

	// Hardware levels override the two serial bits
	assign preq1_v = {preq1_r[7:2], lvl.tx1_empty, lvl.rx1_full}; // R19 R18
	assign preq2_v = {preq2_r[7:2], lvl.tx2_empty, lvl.rx2_full} & PREQ2_IMPL;
	assign pend = |((preq1_v & pen1_r) | (preq2_v & pen2_r)); // R13
	assign sc_v = {pend, sc_r[6:0]};

	vic_vector_arb vic_vector_arb_inst (
		.sc(sc_v),
		.gid(gid_r),
		.req(req),
		.sel(sel),
		.vec(vec)
	);

	assign take = ce && instr_end && req;

	// Clearing an enable while its flag is up, interrupts on, restarts at 0x00
	always_comb begin
		hazard = 1'b0;
		if (wr_en && idx == IDX_STATUS_CTRL && !gid_r) begin
			hazard = (sc_r[SC_EXT_E] && !wbyte[SC_EXT_E] && sc_r[SC_EXT_F]) ||
				(sc_r[SC_T0_E] && !wbyte[SC_T0_E] && sc_r[SC_T0_F]) ||
				(sc_r[SC_TCLK_E] && !wbyte[SC_TCLK_E] && sc_r[SC_TCLK_F]) ||
				(sc_r[SC_PGRP_E] && !wbyte[SC_PGRP_E] && pend); // R14
		end
	end

	// Event stage: one cycle of recognition latency
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_r <= '0;
		end else if (ce) begin
			evt_r <= evt; // R11
		end
	end

	// Status/control flags and enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sc_r <= RST_ZERO; // R16
		end else if (ce) begin
			logic [7:0] set;
			logic [7:0] clr;
			set = '0;
			clr = '0;
			set[SC_EXT_F] = evt_r.ext_pin; // R10
			set[SC_T0_F] = evt_r.t0_ovf;
			set[SC_TCLK_F] = evt_r.tclk_pin;
			if (wr_en && idx == IDX_STATUS_CTRL) begin
				clr[6:4] = ~wbyte[6:4];
				set[3:0] = wbyte[3:0]; // R16
				clr[3:0] = ~wbyte[3:0];
			end
			if (take) begin
				clr[SC_EXT_F] = clr[SC_EXT_F] | (sel == SEL_EXT); // R5
				clr[SC_T0_F] = clr[SC_T0_F] | (sel == SEL_T0); // R6
				clr[SC_TCLK_F] = clr[SC_TCLK_F] | (sel == SEL_TCLK); // R7
			end
			sc_r <= set_wins(sc_r, set, clr) & 8'h7F;
		end
	end

	// Peripheral enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pen1_r <= RST_ZERO;
			pen2_r <= RST_ZERO;
		end else if (ce && wr_en) begin
			if (idx == IDX_PEN1) begin
				pen1_r <= wbyte; // R17
			end
			if (idx == IDX_PEN2) begin
				pen2_r <= wbyte & PREQ2_IMPL;
			end
		end
	end

	// Peripheral requests; a take never touches them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			preq1_r <= RST_ZERO;
			preq2_r <= RST_ZERO;
		end else if (ce) begin
			logic [7:0] s1;
			logic [7:0] s2;
			logic [7:0] c1;
			logic [7:0] c2;
			s1 = {evt_r.port_chg, evt_r.tmr3, evt_r.tmr2, evt_r.tmr1, evt_r.cap2, evt_r.cap1,
				2'b00}; // R1 R10
			s2 = {evt_r.ssp, evt_r.bus_coll, evt_r.adc_done, 1'b0, evt_r.cap4, evt_r.cap3,
				2'b00};
			c1 = (wr_en && idx == IDX_PREQ1) ? ~wbyte & ~PREQ_HW_MASK : 8'h00;
			c2 = (wr_en && idx == IDX_PREQ2) ? ~wbyte & ~PREQ_HW_MASK : 8'h00;
			preq1_r <= set_wins(preq1_r, s1, c1) & ~PREQ_HW_MASK; // R8 R18
			preq2_r <= set_wins(preq2_r, s2, c2) & PREQ2_IMPL & ~PREQ_HW_MASK;
		end
	end

	// Global disable: take sets it, return or software clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gid_r <= RST_GID;
		end else if (ce) begin
			if (take || hazard) begin
				gid_r <= 1'b1; // R3
			end else if (return_from_isr) begin
				gid_r <= 1'b0; // R12
			end else if (wr_en && idx == IDX_CORE_STATUS) begin
				gid_r <= wbyte[CS_GID];
			end
		end
	end

	// Core handshake: pulses last one enabled cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			push_r <= 1'b0;
			load_r <= 1'b0;
			pop_r <= 1'b0;
			vec_r <= VEC_RESET;
			state_r <= ST_RUN;
		end else if (ce) begin
			push_r <= take; // R3
			load_r <= take || hazard;
			pop_r <= return_from_isr && !take; // R12
			if (hazard) begin
				vec_r <= VEC_RESET; // R14
			end else if (take) begin
				vec_r <= vec; // R3
			end
			case (state_r)
				ST_RUN: begin
					if (take) begin
						state_r <= ST_ISR;
					end
				end
				ST_ISR: begin
					if (return_from_isr || hazard) begin
						state_r <= ST_RUN;
					end
				end
				default: begin
					state_r <= ST_RUN;
				end
			endcase
		end
	end

	// Read data captured in the setup phase, so the access phase has no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= '0;
			slverr_r <= 1'b0;
		end else if (ce && setup) begin
			slverr_r <= !(mapped(idx) && paddr[11:10] == 2'b00);
			case (idx)
				IDX_CORE_STATUS: prdata_r <= {31'h0000_0000, gid_r};
				IDX_STATUS_CTRL: prdata_r <= {24'h00_0000, sc_v}; // R13
				IDX_PREQ1: prdata_r <= {24'h00_0000, preq1_v};
				IDX_PEN1: prdata_r <= {24'h00_0000, pen1_r};
				IDX_PREQ2: prdata_r <= {24'h00_0000, preq2_v};
				IDX_PEN2: prdata_r <= {24'h00_0000, pen2_r};
				default: prdata_r <= '0;
			endcase
		end
	end

	assign prdata = prdata_r;
	assign pslverr = slverr_r && psel && penable;
	assign core.push_ret = push_r;
	assign core.load_pc = load_r;
	assign core.pop_ret = pop_r;
	assign core.vec_addr = vec_r;
	assign global_irq_disable = gid_r;
	assign in_isr = (state_r == ST_ISR);

	sequence s_take_ext;
		ce && take && sel == SEL_EXT && !evt_r.ext_pin;
	endsequence

	sequence s_ext_seen;
		ce && evt.ext_pin ##1 ce;
	endsequence

	a_take_sets_disable: assert property (@(posedge pclk) disable iff (!presetn) // R3
		take |=> gid_r && push_r && load_r &&
		vec_r == ($past(hazard) ? VEC_RESET : $past(vec)))
		else $error("take did not set disable or load vector");

	a_disable_blocks: assert property (@(posedge pclk) disable iff (!presetn) // R2
		gid_r |-> !take)
		else $error("vector taken while disabled");

	a_ext_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) // R5
		s_take_ext |=> !sc_r[SC_EXT_F] && vec_r == ($past(hazard) ? VEC_RESET : VEC_EXT))
		else $error("external flag not cleared on its vector");

	a_t0_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) // R6
		ce && take && sel == SEL_T0 && !evt_r.t0_ovf |=> !sc_r[SC_T0_F] &&
		vec_r == ($past(hazard) ? VEC_RESET : VEC_T0))
		else $error("timer0 flag not cleared on its vector");

	a_tclk_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) // R7
		ce && take && sel == SEL_TCLK && !evt_r.tclk_pin |=> !sc_r[SC_TCLK_F])
		else $error("clock edge flag not cleared on its vector");

	a_periph_keep: assert property (@(posedge pclk) disable iff (!presetn) // R8
		ce && take && sel == SEL_PERIPH && !wr_en |=> (preq1_r & $past(preq1_r)) ==
		$past(preq1_r) && vec_r == VEC_PERIPH)
		else $error("peripheral vector altered request flags");

	a_ext_latency: assert property (@(posedge pclk) disable iff (!presetn) // R11 R10
		s_ext_seen |=> sc_r[SC_EXT_F])
		else $error("external event not flagged within two cycles");

	a_return_pops: assert property (@(posedge pclk) disable iff (!presetn) // R12
		ce && return_from_isr && !take && !hazard |=> !gid_r && pop_r)
		else $error("return did not clear disable");

	a_hazard_reset: assert property (@(posedge pclk) disable iff (!presetn) // R14
		hazard |=> load_r && vec_r == VEC_RESET && gid_r)
		else $error("enable clear hazard did not vector to zero");

	a_priority_ext: assert property (@(posedge pclk) disable iff (!presetn) // R21 R20
		take && sc_r[SC_EXT_F] && sc_r[SC_EXT_E] |-> sel == SEL_EXT)
		else $error("external pin not served first");

endmodule // vic_top

// ==== sim/vic_core_model.sv ====
// Core sequencer model facing the controller: stack depth, vector log.
// Assumes single-cycle instructions unless the bench stalls the core.
`timescale 1ns/10ps
module vic_core_model import vic_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Controller side
	input wire vic_core_t core,
	output logic instr_end,
	output logic return_from_isr,
	// Bench control
	input wire logic stall,
	input wire logic ret_req,
	// Observation
	output int loads,
	output int pushes,
	output int depth,
	output logic [15:0] last_vec
);
	// Stall models a long instruction holding off the boundary
	assign instr_end = presetn & ~stall;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			return_from_isr <= 1'b0;
			loads <= 0;
			pushes <= 0;
			depth <= 0;
			last_vec <= 16'h0000;
		end else begin
			return_from_isr <= ret_req;
			if (core.load_pc) begin
				loads <= loads + 1;
				last_vec <= core.vec_addr;
			end
			if (core.push_ret && !core.pop_ret)
				depth <= depth + 1;
			if (core.pop_ret && !core.push_ret)
				depth <= depth - 1;
			if (core.push_ret)
				pushes <= pushes + 1;
		end
	end
endmodule // vic_core_model

// ==== sim/vic_top_bench.sv ====
// Self-checking bench of the interrupt controller over APB.
// Assumes ce high for every access; only the freeze scenario lowers it, with no access.
`timescale 1ns/10ps
module vic_top_bench import vic_pkg::*;;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic stall = 0, ret_req = 0, pready, pslverr, se, instr_end, ret, gid, in_isr;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [15:0] last_vec;
	vic_evt_t evt = '0;
	vic_lvl_t lvl = '0;
	vic_core_t core;
	int loads, pushes, depth, err_count = 0, samples_checked = 0, cyc = 0;

	vic_top vic_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt), .lvl(lvl),
		.instr_end(instr_end), .return_from_isr(ret), .core(core),
		.global_irq_disable(gid), .in_isr(in_isr));
	vic_core_model vic_core_model_inst (.pclk(pclk), .presetn(presetn), .core(core),
		.instr_end(instr_end), .return_from_isr(ret), .stall(stall),
		.ret_req(ret_req), .loads(loads), .pushes(pushes), .depth(depth),
		.last_vec(last_vec));

	initial forever #2 pclk = ~pclk;

	task give_verdict;
		$display("checked %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Hang guard well above the roughly 130 cycles of the run
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 5000) begin
			err_count++;
			give_verdict;
		end
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		paddr <= {2'b00, idx, 2'b00};
		pwrite <= w;
		pwdata <= {24'h000000, wd};
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task rdc(input string nm, input logic [7:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 8'h00);
		chk(nm, {24'h000000, e}, rd);
	endtask

	task pulse(input vic_evt_t e);
		evt <= e;
		@(posedge pclk);
		evt <= '0;
		repeat (2) @(posedge pclk);
	endtask

	task wl(input int n);
		for (int i = 0; i < 64 && loads < n; i++) @(posedge pclk);
		if (loads < n) begin
			err_count++;
			$display("MISMATCH vector wait expected %0d seen %0d", n, loads);
		end
	endtask

	task isr_ret;
		ret_req <= 1'b1;
		@(posedge pclk);
		ret_req <= 1'b0;
	endtask

	task t_reset;
		rdc("status", IDX_STATUS_CTRL, 8'h00);
		rdc("pen1", IDX_PEN1, 8'h00);
		rdc("cstat", IDX_CORE_STATUS, 8'h01);
		apb(1'b0, 8'h3F, 8'h00);
		chk("slverr", 32'h1, {31'h0, se});
		apb(1'b1, IDX_PEN1, 8'hA5);
		rdc("pen1", IDX_PEN1, 8'hA5);
		apb(1'b1, IDX_PEN1, 8'h5A);
		rdc("pen1", IDX_PEN1, 8'h5A);
		apb(1'b1, IDX_PEN1, 8'h00);
	endtask

	task t_masked;
		pulse('{ext_pin: 1'b1, t0_ovf: 1'b1, tclk_pin: 1'b1, default: 1'b0});
		rdc("status", IDX_STATUS_CTRL, 8'h70);
		apb(1'b1, IDX_STATUS_CTRL, 8'h77);
		repeat (4) @(posedge pclk);
		chk("loads", 32'd0, loads);
	endtask

	task t_prio;
		apb(1'b1, IDX_CORE_STATUS, 8'h00);
		wl(1);
		chk("vec", {16'h0, VEC_EXT}, {16'h0, last_vec});
		chk("gid", 32'h1, {31'h0, gid});
		chk("push", 32'd1, pushes);
		chk("in_isr", 32'h1, {31'h0, in_isr});
		rdc("status", IDX_STATUS_CTRL, 8'h67);
		isr_ret;
		wl(2);
		chk("vec", {16'h0, VEC_T0}, {16'h0, last_vec});
		rdc("status", IDX_STATUS_CTRL, 8'h47);
		isr_ret;
		wl(3);
		chk("vec", {16'h0, VEC_TCLK}, {16'h0, last_vec});
		rdc("status", IDX_STATUS_CTRL, 8'h07);
		isr_ret;
		repeat (4) @(posedge pclk);
		chk("gid", 32'h0, {31'h0, gid});
		chk("depth", 32'd0, depth);
		chk("in_isr", 32'h0, {31'h0, in_isr});
	endtask

	task t_periph;
		apb(1'b1, IDX_PEN1, 8'h04);
		pulse('{cap1: 1'b1, default: 1'b0});
		rdc("status", IDX_STATUS_CTRL, 8'h87);
		chk("loads", 32'd3, loads);
		apb(1'b1, IDX_STATUS_CTRL, 8'h0F);
		wl(4);
		chk("vec", {16'h0, VEC_PERIPH}, {16'h0, last_vec});
		rdc("preq1", IDX_PREQ1, 8'h04);
		apb(1'b1, IDX_PREQ1, 8'h00);
		rdc("status", IDX_STATUS_CTRL, 8'h0F);
		isr_ret;
		repeat (6) @(posedge pclk);
		chk("loads", 32'd4, loads);
		lvl <= '{rx1_full: 1'b1, default: 1'b0};
		@(posedge pclk);
		apb(1'b1, IDX_PREQ1, 8'h00);
		rdc("preq1", IDX_PREQ1, 8'h01);
		lvl <= '0;
	endtask

	task t_hazard;
		apb(1'b1, IDX_CORE_STATUS, 8'h01);
		apb(1'b1, IDX_STATUS_CTRL, 8'h02);
		pulse('{t0_ovf: 1'b1, default: 1'b0});
		stall <= 1'b1;
		apb(1'b1, IDX_CORE_STATUS, 8'h00);
		apb(1'b1, IDX_STATUS_CTRL, 8'h20);
		wl(5);
		chk("vec", {16'h0, VEC_RESET}, {16'h0, last_vec});
		chk("push", 32'd4, pushes);
		chk("gid", 32'h1, {31'h0, gid});
		stall <= 1'b0;
	endtask

	// A return seen while frozen must not pop or clear the disable
	task t_freeze;
		ce <= 1'b0;
		isr_ret;
		repeat (2) @(posedge pclk);
		chk("pready", 32'h0, {31'h0, pready});
		ce <= 1'b1;
		@(posedge pclk);
		chk("gid", 32'h1, {31'h0, gid});
		chk("depth", 32'd0, depth);
	endtask

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_masked;
		t_prio;
		t_periph;
		t_hazard;
		t_freeze;
		give_verdict;
	end
endmodule // vic_top_bench
